// File: rtl/lmac_ctrl.sv
// Long-mode enable/activate control registers, consistency checks and mode outputs.
`timescale 1ns/100ps
`include "lmac_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
module lmac_ctrl
  import lmac_pkg::*;
(
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire lmac_bus_req_type bus_req,
  output logic [31:0]           rdata,
  input  wire lmac_prefix_type  prefix,
  output lmac_mode_type         mode,
  output logic                  general_protection_fault,
  output logic [15:0]           gp_error_code,
  output logic                  long_mode_active_bit,
  output logic                  paging_enable_bit
);

  logic [31:0]   control_reg_zero;
  logic [31:0]   feature_ctrl_reg;
  logic [31:0]   extended_feature_reg;
  logic [63:0]   page_table_base_reg;
  logic [1:0]    code_attr_reg;
  logic [31:0]   global_table_base_reg;
  logic [31:0]   interrupt_table_base_reg;
  logic [15:0]   local_table_selector_reg;
  logic [15:0]   task_state_selector_reg;
  logic          fault_seen;
  lmac_mode_type next_mode;

  logic          pg;
  logic          pae;
  logic          lme;
  logic          cs_l;
  logic          cs_d;
  logic          lme_flip;
  logic          pg_rise;
  logic          pae_missing;
  logic          long_code;
  logic          pae_drop;
  logic          fault_now;

  function automatic logic lmac_hit(input lmac_bus_req_type req, input logic [7:0] off);
    lmac_hit = req.wr && (req.addr == off);
  endfunction

  assign pg                = control_reg_zero[`LMAC_PG_BIT];
  assign pae               = feature_ctrl_reg[`LMAC_PAE_BIT];
  assign lme               = extended_feature_reg[`LMAC_LME_BIT];
  assign cs_l              = code_attr_reg[`LMAC_CS_L_BIT];
  assign cs_d              = code_attr_reg[`LMAC_CS_D_BIT];
  assign paging_enable_bit = pg;

  //////////////////////////////////////////////////////////////////////////////
  // Consistency checks on control-bit transitions.

  assign lme_flip    = lmac_hit(bus_req, `LMAC_OFF_EXT_FEATURE) && pg &&
                       (bus_req.wdata[`LMAC_LME_BIT] != lme);
  assign pg_rise     = lmac_hit(bus_req, `LMAC_OFF_CTRL_ZERO) &&
                       bus_req.wdata[`LMAC_PG_BIT] && !pg;
  assign pae_missing = pg_rise && lme && !pae;
  assign long_code   = pg_rise && lme && cs_l;
  assign pae_drop    = lmac_hit(bus_req, `LMAC_OFF_FEATURE_CTRL) && pae &&
                       !bus_req.wdata[`LMAC_PAE_BIT] && long_mode_active_bit;
  // A failing write is dropped whole, so the faulting register keeps its old value.
  assign fault_now   = lme_flip || pae_missing || long_code || pae_drop;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      general_protection_fault <= 1'b0;
      gp_error_code            <= `LMAC_GP_ERROR_CODE;
    end else if (ce) begin
      general_protection_fault <= fault_now;
      if (fault_now) begin
        gp_error_code <= `LMAC_GP_ERROR_CODE;
      end
    end
  end

  // A fault in the same cycle as a software clear stays recorded.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fault_seen <= 1'b0;
    end else if (ce) begin
      if (fault_now) begin
        fault_seen <= 1'b1;
      end else if (lmac_hit(bus_req, `LMAC_OFF_STATUS) &&
                   bus_req.wdata[`LMAC_STS_FAULT_BIT]) begin
        fault_seen <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control registers.

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      control_reg_zero <= `LMAC_RST_WORD;
    end else if (ce && lmac_hit(bus_req, `LMAC_OFF_CTRL_ZERO) && !fault_now) begin
      control_reg_zero <= bus_req.wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      feature_ctrl_reg <= `LMAC_RST_WORD;
    end else if (ce && lmac_hit(bus_req, `LMAC_OFF_FEATURE_CTRL) && !fault_now) begin
      feature_ctrl_reg <= bus_req.wdata;
    end
  end

  // The active bit is hardware-owned; software writes to its position are dropped.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      extended_feature_reg <= `LMAC_RST_WORD;
    end else if (ce && lmac_hit(bus_req, `LMAC_OFF_EXT_FEATURE) && !fault_now) begin
      extended_feature_reg                <= bus_req.wdata;
      extended_feature_reg[`LMAC_LMA_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      long_mode_active_bit <= 1'b0;
    end else if (ce && lmac_hit(bus_req, `LMAC_OFF_CTRL_ZERO) && !fault_now) begin
      if (pg_rise && lme) begin
        long_mode_active_bit <= 1'b1;
      end else if (!bus_req.wdata[`LMAC_PG_BIT]) begin
        long_mode_active_bit <= 1'b0;
      end
    end
  end

  // The high half only takes writes once long mode is active.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      page_table_base_reg <= {`LMAC_RST_WORD, `LMAC_RST_WORD};
    end else if (ce) begin
      if (lmac_hit(bus_req, `LMAC_OFF_PTB_LO)) begin
        page_table_base_reg[31:0] <= bus_req.wdata;
      end
      if (lmac_hit(bus_req, `LMAC_OFF_PTB_HI) && long_mode_active_bit) begin
        page_table_base_reg[63:32] <= bus_req.wdata;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      code_attr_reg <= 2'h0;
    end else if (ce && lmac_hit(bus_req, `LMAC_OFF_CODE_ATTR)) begin
      code_attr_reg <= bus_req.wdata[1:0];
    end
  end

  // Descriptor-table registers change only on their own writes.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      global_table_base_reg    <= `LMAC_RST_WORD;
      interrupt_table_base_reg <= `LMAC_RST_WORD;
      local_table_selector_reg <= `LMAC_RST_SEL;
      task_state_selector_reg  <= `LMAC_RST_SEL;
    end else if (ce) begin
      if (lmac_hit(bus_req, `LMAC_OFF_GLOBAL_TABLE)) begin
        global_table_base_reg <= bus_req.wdata;
      end
      if (lmac_hit(bus_req, `LMAC_OFF_INTR_TABLE)) begin
        interrupt_table_base_reg <= bus_req.wdata;
      end
      if (lmac_hit(bus_req, `LMAC_OFF_LOCAL_SEL)) begin
        local_table_selector_reg <= bus_req.wdata[15:0];
      end
      if (lmac_hit(bus_req, `LMAC_OFF_TASK_SEL)) begin
        task_state_selector_reg <= bus_req.wdata[15:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Mode outputs, registered so the core sees a clean value each cycle.

  lmac_mode_decode u_decode (
    .long_mode_active_bit (long_mode_active_bit),
    .cs_l                 (cs_l),
    .cs_d                 (cs_d),
    .prefix               (prefix),
    .next_mode            (next_mode)
  );

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mode          <= '0;
      mode.submode  <= LMAC_SUB_LEGACY;
      mode.def_addr <= LMAC_SZ16;
      mode.def_op   <= LMAC_SZ16;
      mode.eff_addr <= LMAC_SZ16;
      mode.eff_op   <= LMAC_SZ16;
    end else if (ce) begin
      mode <= next_mode;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read port: data stand after the strobe until the next enabled cycle, which loads zero if it has no strobe.

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdata <= 32'h0000_0000;
    end else if (ce) begin
      rdata <= 32'h0000_0000;
      if (bus_req.rd) begin
        case (bus_req.addr)
          `LMAC_OFF_CTRL_ZERO:    rdata <= control_reg_zero;
          `LMAC_OFF_FEATURE_CTRL: rdata <= feature_ctrl_reg;
          `LMAC_OFF_EXT_FEATURE: begin
            rdata                <= extended_feature_reg;
            rdata[`LMAC_LMA_BIT] <= long_mode_active_bit;
          end
          `LMAC_OFF_PTB_LO:       rdata <= page_table_base_reg[31:0];
          `LMAC_OFF_PTB_HI:       rdata <= page_table_base_reg[63:32];
          `LMAC_OFF_CODE_ATTR:    rdata <= {30'h0000_0000, code_attr_reg};
          `LMAC_OFF_GLOBAL_TABLE: rdata <= global_table_base_reg;
          `LMAC_OFF_INTR_TABLE:   rdata <= interrupt_table_base_reg;
          `LMAC_OFF_LOCAL_SEL:    rdata <= {16'h0000, local_table_selector_reg};
          `LMAC_OFF_TASK_SEL:     rdata <= {16'h0000, task_state_selector_reg};
          `LMAC_OFF_STATUS: begin
            rdata[`LMAC_STS_FAULT_BIT]                            <= fault_seen;
            rdata[`LMAC_STS_SUBMODE_LSB+3:`LMAC_STS_SUBMODE_LSB]  <= mode.submode;
            rdata[`LMAC_STS_DEF_ADDR_LSB+1:`LMAC_STS_DEF_ADDR_LSB] <= mode.def_addr;
            rdata[`LMAC_STS_DEF_OP_LSB+1:`LMAC_STS_DEF_OP_LSB]    <= mode.def_op;
          end
          default:                rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions.

  lma_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && pg_rise && lme && pae && !cs_l |=> long_mode_active_bit && pg)
    else $error("long mode not activated by paging enable");

  legacy_size_a: assert property (@(posedge mclk) disable iff (!rst_n)
    mode.submode == LMAC_SUB_LEGACY |-> mode.def_addr != LMAC_SZ64 &&
      mode.eff_op != LMAC_SZ64 && mode.eff_addr != LMAC_SZ64)
    else $error("64-bit size seen in legacy mode");

  sub64_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && long_mode_active_bit && cs_l && !cs_d |=> mode.submode == LMAC_SUB_LONG64 &&
      mode.def_addr == LMAC_SZ64 && mode.def_op == LMAC_SZ32)
    else $error("64-bit submode defaults wrong");

  prefix_64_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && long_mode_active_bit && cs_l && !cs_d && prefix.wide_op && prefix.addr_ovr
      |=> mode.eff_op == LMAC_SZ64 && mode.eff_addr == LMAC_SZ32)
    else $error("64-bit submode override wrong");

  reserved_enc_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && long_mode_active_bit && cs_l && cs_d |=> mode.reserved_enc)
    else $error("reserved encoding not flagged");

  compat_mode_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && long_mode_active_bit && !cs_l |=> mode.submode == LMAC_SUB_COMPAT &&
      mode.def_op == ($past(cs_d) ? LMAC_SZ32 : LMAC_SZ16))
    else $error("compatibility submode wrong");

  lme_guard_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && lme_flip |=> general_protection_fault && gp_error_code == 16'h0000 &&
      lme == $past(lme))
    else $error("long enable changed under paging");

  pae_guard_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && pg_rise && lme && !pae |=> general_protection_fault && !pg &&
      !long_mode_active_bit)
    else $error("paging enabled without address extension");

  code_guard_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && pg_rise && lme && cs_l |=> general_protection_fault && !pg)
    else $error("paging enabled with long code segment");

  pae_drop_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && pae_drop |=> general_protection_fault && pae)
    else $error("address extension cleared while active");

  tables_kept_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(long_mode_active_bit) |-> $stable(interrupt_table_base_reg) &&
      $stable(global_table_base_reg))
    else $error("descriptor table changed on activation");

  ptb_high_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && lmac_hit(bus_req, `LMAC_OFF_PTB_HI) && !long_mode_active_bit
      |=> $stable(page_table_base_reg[63:32]))
    else $error("high page base written in legacy mode");

  lma_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && lmac_hit(bus_req, `LMAC_OFF_CTRL_ZERO) && !bus_req.wdata[`LMAC_PG_BIT]
      |=> !long_mode_active_bit)
    else $error("active bit not cleared with paging");

  // The attribute may be rewritten in the same cycle, so compare against its old value.
  legacy_attr_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && !long_mode_active_bit |=> mode.submode == LMAC_SUB_LEGACY &&
      mode.def_addr == ($past(cs_d) ? LMAC_SZ32 : LMAC_SZ16) && !mode.reserved_enc)
    else $error("legacy defaults wrong");

  opsize_64_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && long_mode_active_bit && cs_l && !cs_d && prefix.opsize_ovr && !prefix.wide_op &&
      !prefix.addr_ovr |=> mode.eff_op == LMAC_SZ16 && mode.eff_addr == LMAC_SZ64)
    else $error("64-bit submode operand override wrong");

  fault_pulse_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && !fault_now |=> !general_protection_fault)
    else $error("fault raised without a failing write");

  rdata_idle_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && !bus_req.rd |=> rdata == 32'h0000_0000)
    else $error("read data not cleared after read cycle");

endmodule

// File: rtl/lmac_cfg.svh
// Offsets, field positions, reset values and fixed codes of the long-mode control block.
`ifndef LMAC_CFG_SVH
`define LMAC_CFG_SVH

`define LMAC_ADDR_W            8
`define LMAC_DATA_W            32

`define LMAC_OFF_CTRL_ZERO     8'h00
`define LMAC_OFF_FEATURE_CTRL  8'h04
`define LMAC_OFF_EXT_FEATURE   8'h08
`define LMAC_OFF_PTB_LO        8'h0c
`define LMAC_OFF_PTB_HI        8'h10
`define LMAC_OFF_CODE_ATTR     8'h14
`define LMAC_OFF_GLOBAL_TABLE  8'h18
`define LMAC_OFF_INTR_TABLE    8'h1c
`define LMAC_OFF_LOCAL_SEL     8'h20
`define LMAC_OFF_TASK_SEL      8'h24
`define LMAC_OFF_STATUS        8'h28

`define LMAC_PG_BIT            31
`define LMAC_PAE_BIT           5
`define LMAC_LME_BIT           8
`define LMAC_LMA_BIT           10
`define LMAC_CS_L_BIT          0
`define LMAC_CS_D_BIT          1
`define LMAC_STS_FAULT_BIT     0
`define LMAC_STS_SUBMODE_LSB   4
`define LMAC_STS_DEF_ADDR_LSB  8
`define LMAC_STS_DEF_OP_LSB    10

`define LMAC_RST_WORD          32'h0000_0000
`define LMAC_RST_SEL           16'h0000
`define LMAC_GP_ERROR_CODE     16'h0000

`endif

// File: rtl/lmac_pkg.sv
// Types shared by the long-mode control block.
package lmac_pkg;

  typedef enum logic [3:0] {
    LMAC_SUB_LEGACY   = 4'b0001,
    LMAC_SUB_COMPAT   = 4'b0010,
    LMAC_SUB_LONG64   = 4'b0100,
    LMAC_SUB_RESERVED = 4'b1000
  } lmac_submode_type;

  typedef enum logic [1:0] {
    LMAC_SZ16 = 2'h0,
    LMAC_SZ32 = 2'h1,
    LMAC_SZ64 = 2'h2
  } lmac_size_type;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } lmac_bus_req_type;

  typedef struct packed {
    logic opsize_ovr;
    logic addr_ovr;
    logic wide_op;
  } lmac_prefix_type;

  typedef struct packed {
    lmac_submode_type submode;
    lmac_size_type    def_addr;
    lmac_size_type    def_op;
    lmac_size_type    eff_addr;
    lmac_size_type    eff_op;
    logic             reserved_enc;
  } lmac_mode_type;

endpackage

// File: rtl/lmac_mode_decode.sv
// Submode selection and default/effective size decode from the mode bits.
`timescale 1ns/100ps
module lmac_mode_decode
  import lmac_pkg::*;
(
  input  wire logic            long_mode_active_bit,
  input  wire logic            cs_l,
  input  wire logic            cs_d,
  input  wire lmac_prefix_type prefix,
  output lmac_mode_type        next_mode
);

  // Outside 64-bit submode a size prefix swaps between 16 and 32 bits.
  function automatic lmac_size_type lmac_toggle(input lmac_size_type sz, input logic ovr);
    lmac_toggle = sz;
    if (ovr) begin
      lmac_toggle = (sz == LMAC_SZ32) ? LMAC_SZ16 : LMAC_SZ32;
    end
  endfunction

  always_comb begin
    next_mode              = '0;
    next_mode.submode      = LMAC_SUB_LEGACY;
    next_mode.def_addr     = cs_d ? LMAC_SZ32 : LMAC_SZ16;
    next_mode.def_op       = cs_d ? LMAC_SZ32 : LMAC_SZ16;
    next_mode.reserved_enc = 1'b0;
    if (long_mode_active_bit && cs_l && !cs_d) begin
      next_mode.submode  = LMAC_SUB_LONG64;
      next_mode.def_addr = LMAC_SZ64;
      next_mode.def_op   = LMAC_SZ32;
    end else if (long_mode_active_bit && cs_l) begin
      // Reserved pairing keeps 32-bit defaults, selects the reserved submode and raises a flag.
      next_mode.submode      = LMAC_SUB_RESERVED;
      next_mode.def_addr     = LMAC_SZ32;
      next_mode.def_op       = LMAC_SZ32;
      next_mode.reserved_enc = 1'b1;
    end else if (long_mode_active_bit) begin
      next_mode.submode = LMAC_SUB_COMPAT;
    end
    // Legacy ignores the long attribute entirely.
    if (next_mode.submode == LMAC_SUB_LONG64) begin
      next_mode.eff_op   = prefix.wide_op ? LMAC_SZ64 :
                           (prefix.opsize_ovr ? LMAC_SZ16 : LMAC_SZ32);
      next_mode.eff_addr = prefix.addr_ovr ? LMAC_SZ32 : LMAC_SZ64;
    end else begin
      next_mode.eff_op   = lmac_toggle(next_mode.def_op, prefix.opsize_ovr);
      next_mode.eff_addr = lmac_toggle(next_mode.def_addr, prefix.addr_ovr);
    end
  end

endmodule

// File: tb/lmac_ctrl_tb_top.sv
// Self-checking bench for the long-mode control block.
`timescale 1ns/100ps
`include "lmac_cfg.svh"
module lmac_ctrl_tb_top
  import lmac_pkg::*;
();

  typedef struct packed {
    logic [31:0] d;
    logic [31:0] m;
  } lmac_tb_exp_type;

  logic             mclk;
  logic             rst_n;
  logic             ce;
  lmac_bus_req_type bus_req;
  lmac_prefix_type  prefix;
  logic [31:0]      rdata;
  lmac_mode_type    mode;
  logic             gpf;
  logic [15:0]      gp_code;
  logic             lma;
  logic             pg;
  int               n_fail;
  int               checked;
  int               cycles;
  logic [15:0]      seed;
  lmac_tb_exp_type  rq [$];
  logic             fq [$];

  lmac_ctrl uut (
    .mclk                     (mclk),
    .rst_n                    (rst_n),
    .ce                       (ce),
    .bus_req                  (bus_req),
    .rdata                    (rdata),
    .prefix                   (prefix),
    .mode                     (mode),
    .general_protection_fault (gpf),
    .gp_error_code            (gp_code),
    .long_mode_active_bit     (lma),
    .paging_enable_bit        (pg)
  );

  always #2.5 mclk = ~mclk;

////////////////////////////////////////////////////////////////////////////////
  task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_flag(input string name, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic test_done();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic next_rnd(output logic [31:0] v);
    seed = lfsr(seed);
    v[31:16] = seed;
    seed = lfsr(seed);
    v[15:0] = seed;
  endtask

  // Each request is launched after an edge and noted at once, so the monitor pops in order.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic f);
    @(posedge mclk);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    fq.push_back(f);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    @(posedge mclk);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    rq.push_back('{d: d, m: m});
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge mclk) bus_req <= '0;
    #1;
  endtask

////////////////////////////////////////////////////////////////////////////////
  // Results stand for one cycle after the edge that took the request, so look 1 ns later.
  always @(posedge mclk) begin : monitor
    logic            took_rd;
    logic            took_wr;
    lmac_tb_exp_type e;
    took_rd = ce && rst_n && bus_req.rd;
    took_wr = ce && rst_n && bus_req.wr;
    #1;
    if (took_rd) begin
      e = rq.pop_front();
      chk_word("rdata", e.d & e.m, rdata & e.m);
    end
    if (took_wr)
      chk_flag("fault", fq.pop_front(), gpf);
    else
      chk_flag("fault idle", 1'b0, gpf);
    if (gpf === 1'b1)
      chk_word("error code", 32'h0, {16'h0, gp_code});
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      $display("ERROR timeout expected finish seen hang");
      test_done();
    end
  end

////////////////////////////////////////////////////////////////////////////////
  initial begin : main
    logic [31:0] tbl [4];
    logic [31:0] st [4];
    logic [31:0] lo;
    logic [31:0] hi;
    mclk = 1'b0;
    rst_n = 1'b0;
    ce = 1'b1;
    bus_req = '0;
    prefix = '0;
    n_fail = 0;
    checked = 0;
    cycles = 0;
    seed = 16'h645b;
    st = '{32'h20, 32'h640, 32'h520, 32'h580};
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    idle(2);
    for (int a = 0; a < 11; a++)
      rd(8'(a * 4), (a == 10) ? 32'h10 : 32'h0, 32'hffff_ffff);
    rd(8'h2c, 32'h0, 32'hffff_ffff);
    wr(`LMAC_OFF_CODE_ATTR, 32'h3, 1'b0);
    idle(3);
    chk_word("legacy sizes", {28'h0, LMAC_SZ32, LMAC_SZ32}, {28'h0, mode.def_addr, mode.def_op});
    chk_flag("no reserved", 1'b0, mode.reserved_enc);
    // Faulting paging writes must leave paging off.
    wr(`LMAC_OFF_FEATURE_CTRL, 32'h20, 1'b0);
    wr(`LMAC_OFF_EXT_FEATURE, 32'h100, 1'b0);
    wr(`LMAC_OFF_CTRL_ZERO, 32'h8000_0000, 1'b1);
    wr(`LMAC_OFF_CODE_ATTR, 32'h0, 1'b0);
    wr(`LMAC_OFF_FEATURE_CTRL, 32'h0, 1'b0);
    wr(`LMAC_OFF_CTRL_ZERO, 32'h8000_0000, 1'b1);
    wr(`LMAC_OFF_FEATURE_CTRL, 32'h20, 1'b0);
    rd(`LMAC_OFF_CTRL_ZERO, 32'h0, 32'hffff_ffff);
    next_rnd(lo);
    next_rnd(hi);
    wr(`LMAC_OFF_PTB_LO, lo, 1'b0);
    wr(`LMAC_OFF_PTB_HI, hi, 1'b0);
    rd(`LMAC_OFF_PTB_LO, lo, 32'hffff_ffff);
    rd(`LMAC_OFF_PTB_HI, 32'h0, 32'hffff_ffff);
    for (int i = 0; i < 4; i++) begin
      next_rnd(tbl[i]);
      wr(8'(8'h18 + i * 4), tbl[i], 1'b0);
    end
    wr(`LMAC_OFF_CTRL_ZERO, 32'h8000_0000, 1'b0);
    idle(3);
    chk_flag("active", 1'b1, lma);
    chk_flag("paging", 1'b1, pg);
    rd(`LMAC_OFF_EXT_FEATURE, 32'h500, 32'h500);
    for (int i = 0; i < 4; i++)
      rd(8'(8'h18 + i * 4), tbl[i], (i < 2) ? 32'hffff_ffff : 32'h0000_ffff);
    wr(`LMAC_OFF_EXT_FEATURE, 32'h0, 1'b1);
    wr(`LMAC_OFF_EXT_FEATURE, 32'h100, 1'b0);
    wr(`LMAC_OFF_FEATURE_CTRL, 32'h0, 1'b1);
    rd(`LMAC_OFF_EXT_FEATURE, 32'h500, 32'h500);
    rd(`LMAC_OFF_FEATURE_CTRL, 32'h20, 32'h20);
    rd(`LMAC_OFF_STATUS, 32'h1, 32'h1);
    wr(`LMAC_OFF_STATUS, 32'h1, 1'b0);
    rd(`LMAC_OFF_STATUS, 32'h0, 32'h1);
    for (int i = 0; i < 4; i++) begin
      wr(`LMAC_OFF_CODE_ATTR, 32'(i), 1'b0);
      // The mode field trails the attribute write by one cycle.
      idle(1);
      rd(`LMAC_OFF_STATUS, st[i], 32'hff0);
    end
    idle(3);
    chk_flag("reserved", 1'b1, mode.reserved_enc);
    wr(`LMAC_OFF_CODE_ATTR, 32'h1, 1'b0);
    for (int p = 0; p < 8; p++) begin
      @(posedge mclk);
      prefix <= 3'(p);
      bus_req <= '0;
      idle(2);
      chk_word("eff sizes", {28'h0, (p[1] ? LMAC_SZ32 : LMAC_SZ64),
               (p[0] ? LMAC_SZ64 : (p[2] ? LMAC_SZ16 : LMAC_SZ32))},
               {28'h0, mode.eff_addr, mode.eff_op});
    end
    @(posedge mclk);
    prefix <= '0;
    next_rnd(hi);
    wr(`LMAC_OFF_PTB_HI, hi, 1'b0);
    rd(`LMAC_OFF_PTB_HI, hi, 32'hffff_ffff);
    wr(`LMAC_OFF_CTRL_ZERO, 32'h0, 1'b0);
    idle(3);
    chk_flag("inactive", 1'b0, lma);
    chk_word("legacy op", {30'h0, LMAC_SZ16}, {30'h0, mode.eff_op});
    chk_word("legacy mode", {28'h0, LMAC_SUB_LEGACY}, {28'h0, mode.submode});
    rd(`LMAC_OFF_STATUS, 32'h10, 32'hff0);
    rd(`LMAC_OFF_EXT_FEATURE, 32'h100, 32'h500);
    // A write offered while the clock enable is low must not be taken.
    @(posedge mclk);
    ce <= 1'b0;
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: `LMAC_OFF_EXT_FEATURE, wdata: 32'h0};
    @(posedge mclk);
    ce <= 1'b1;
    bus_req <= '0;
    rd(`LMAC_OFF_EXT_FEATURE, 32'h100, 32'h100);
    idle(3);
    test_done();
  end

endmodule
